// File: pmp_map.vh
// Constants for the pattern memory playback engine
// Included by pmp_playback.v; definitions only
`ifndef PMP_MAP_VH
`define PMP_MAP_VH
`define PMP_BIT_DATA 0
`define PMP_BIT_BURST 2
`define PMP_BIT_EVENT 6
`define PMP_BIT_RESET 7
`define PMP_CTRL_ENABLE 0
`define PMP_CTRL_FMT_LO 1
`define PMP_CTRL_FMT_HI 2
`define PMP_CTRL_FRAMED 3
`define PMP_CTRL_PARALLEL 4
`define PMP_CTRL_BPS_LO 5
`define PMP_CTRL_BPS_HI 7
`define PMP_ADDR_CTRL 4'h0
`define PMP_ADDR_STATUS 4'h1
`define PMP_ADDR_LEN 4'h2
`define PMP_ADDR_WADDR 4'h3
`define PMP_ADDR_WDATA 4'h4
`define PMP_ADDR_RATE 4'h5
`define PMP_CTRL_RESET 8'h00
`define PMP_RATE_RESET 16'h0000
`define PMP_MIN_BYTES 60
`define PMP_BURST_DELAY_SYMBOLS 12
`define PMP_MODE_CUSTOM 2'h0
`define PMP_MODE_TDMA 2'h1
`endif

// File: pmp_playback.v
// Pattern memory playback engine with its register port and memory
// Assumes one 125 MHz clock, synchronous active-high reset, symbols paced by a divider
// Summary of operation
// R01: Bit 0 of each played byte is the payload bit to the modulator.
// R02: With burst bit clear, payload bit is don't-care; output forced to zero.
// R03: RF gate follows the burst bit of the byte played twelve symbols earlier.
// R04: Continuous signal needs burst bit set in every byte.
// R05: Framed data sets burst in active slots, clears it in idle slots.
// R06: Only burst, event and reset bits act; four reserved bits ignored.
// R07: Host writes bits 1, 3, 5 as zero and bit 4 as one.
// R08: Event bit set gives one narrow pulse on the event output.
// R09: Host may toggle event bit for pulse trains or start markers.
// R10: Reset bit clear advances address; set ends pattern and restarts.
// R11: Host sets reset bit only in the final pattern byte.
// R12: Byte holds payload plus seven control bits; device adds the rest.
// R13: Valid bytes are sixteen encodings, values 16 to 213.
// R14: Playback only for custom and TDMA formats, TDMA only unframed.
// R15: Output is built from memory bytes, symbol rate, modulation and filter.
// R16: Parallel mode widens the event pulse by bits per symbol.
// R17: Burst change reaches RF output about twelve symbols later.
// R18: Each stored byte expands to a 32-bit word with 24 added bits.
// R19: Patterns under sixty bytes are replicated whole up to the minimum.
// R20: Playback starts at address zero and returns there after a reset byte.
`timescale 1ns/1ps
`include "pmp_map.vh"
module pmp_playback #(
    parameter AW = 12,
    parameter MIN_BYTES = `PMP_MIN_BYTES,
    parameter BURST_DELAY = `PMP_BURST_DELAY_SYMBOLS
) (
    input wire sys_clk,
    input wire srst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg payload_bit,
    output reg rf_gate,
    output reg event_out,
    output reg symbol_strobe,
    output reg [31:0] expanded_word
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PLAY = 2'h1;
    // Control: [0] enable, [2:1] format, [3] tdma framed, [4] parallel, [7:5] bits per symbol
    reg [7:0] ctrl;
    reg [15:0] rate_div;
    reg [AW-1:0] pat_len;
    reg [AW-1:0] wr_ptr;
    reg [7:0] mem [0:(1<<AW)-1];
    reg [1:0] state;
    reg [AW-1:0] play_addr;
    reg [AW-1:0] byte_cnt;
    reg [15:0] div_cnt;
    reg [7:0] cur_byte;
    reg [BURST_DELAY-1:0] burst_pipe;
    reg [3:0] ev_cnt;
    reg [AW-1:0] next_play_addr;
    reg [AW-1:0] next_byte_cnt;
    reg next_event_out;
    reg [3:0] next_ev_cnt;

    function is_valid;
        input [7:0] b;
        begin
            is_valid = (b[1] == 1'b0) && (b[3] == 1'b0) && (b[5] == 1'b0) && b[4];
        end
    endfunction

    // Wrapping increment shared by the write pointer and the play counters
    function [AW-1:0] step;
        input [AW-1:0] v;
        begin
            step = v + 1'b1;
        end
    endfunction

    // Zero-extends an address-wide value onto the 32-bit read bus
    function [31:0] widen;
        input [AW-1:0] v;
        begin
            widen = {{(32-AW){1'b0}}, v};
        end
    endfunction

    wire ctrl_enable = ctrl[`PMP_CTRL_ENABLE];
    wire [1:0] ctrl_format = ctrl[`PMP_CTRL_FMT_HI:`PMP_CTRL_FMT_LO];
    wire ctrl_framed = ctrl[`PMP_CTRL_FRAMED];
    wire ctrl_parallel = ctrl[`PMP_CTRL_PARALLEL];
    wire [2:0] ctrl_bps = ctrl[`PMP_CTRL_BPS_HI:`PMP_CTRL_BPS_LO];
    wire fmt_ok = (ctrl_format == `PMP_MODE_CUSTOM) ||
                  ((ctrl_format == `PMP_MODE_TDMA) && !ctrl_framed); // R14
    wire run = ctrl_enable && fmt_ok;
    wire tick = (div_cnt == rate_div);
    wire [7:0] rd_byte = mem[play_addr];
    wire [3:0] ev_width = ctrl_parallel ? {1'b0, ctrl_bps} : 4'h1; // R16
    // Read-back word: current byte, play address, state
    wire [31:0] play_addr_wide = widen(play_addr);
    wire [31:0] status_word = {8'h00, cur_byte, play_addr_wide[11:0], 2'b00, state};
    // Short pattern wraps at its own end until minimum count reached
    wire short_pat = (pat_len != {AW{1'b0}}) && (pat_len < MIN_BYTES[AW-1:0]);
    wire last_of_copy = short_pat && (play_addr == pat_len - 1'b1);

    // Next play address: reset byte restarts, short copy wraps, otherwise step on
    always @* begin
        next_play_addr = step(play_addr); // R10
        next_byte_cnt = step(byte_cnt);
        if (rd_byte[`PMP_BIT_RESET]) begin
            next_play_addr = {AW{1'b0}}; // R10 R20
            next_byte_cnt = {AW{1'b0}};
        end else if (last_of_copy && (step(byte_cnt) < MIN_BYTES[AW-1:0])) begin
            next_play_addr = {AW{1'b0}}; // R19
        end
    end

    // Event stretch: serial holds one symbol, parallel holds bits per symbol
    always @* begin
        next_event_out = 1'b0;
        next_ev_cnt = ev_cnt;
        if (rd_byte[`PMP_BIT_EVENT]) begin
            next_event_out = 1'b1; // R08
            next_ev_cnt = ev_width; // R16
        end else if (ev_cnt != 4'h0) begin
            next_event_out = (ev_cnt > 4'h1);
            next_ev_cnt = ev_cnt - 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (reg_wr && reg_addr == `PMP_ADDR_WDATA) begin
            mem[wr_ptr] <= reg_wdata[7:0];
        end
    end

    // Register port: writes land next edge, reads answer one cycle later
    always @(posedge sys_clk) begin
        if (srst) begin
            ctrl <= `PMP_CTRL_RESET;
            rate_div <= `PMP_RATE_RESET;
            pat_len <= {AW{1'b0}};
            wr_ptr <= {AW{1'b0}};
            reg_rdata <= 32'h00000000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `PMP_ADDR_CTRL: ctrl <= reg_wdata[7:0];
                    `PMP_ADDR_LEN: pat_len <= reg_wdata[AW-1:0];
                    `PMP_ADDR_WADDR: wr_ptr <= reg_wdata[AW-1:0];
                    `PMP_ADDR_RATE: rate_div <= reg_wdata[15:0];
                    `PMP_ADDR_WDATA: wr_ptr <= step(wr_ptr);
                    default: ;
                endcase
            end
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `PMP_ADDR_CTRL: reg_rdata <= {24'h000000, ctrl};
                    `PMP_ADDR_STATUS: reg_rdata <= status_word;
                    `PMP_ADDR_LEN: reg_rdata <= widen(pat_len);
                    `PMP_ADDR_WADDR: reg_rdata <= widen(wr_ptr);
                    `PMP_ADDR_RATE: reg_rdata <= {16'h0000, rate_div};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Playback: one byte per symbol strobe from the rate divider
    always @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            play_addr <= {AW{1'b0}};
            byte_cnt <= {AW{1'b0}};
            div_cnt <= 16'h0000;
            cur_byte <= 8'h00;
            burst_pipe <= {BURST_DELAY{1'b0}};
            ev_cnt <= 4'h0;
            payload_bit <= 1'b0;
            rf_gate <= 1'b0;
            event_out <= 1'b0;
            symbol_strobe <= 1'b0;
            expanded_word <= 32'h00000000;
        end else begin
            symbol_strobe <= 1'b0;
            case (state)
                ST_IDLE: begin
                    play_addr <= {AW{1'b0}}; // R20
                    byte_cnt <= {AW{1'b0}};
                    div_cnt <= 16'h0000;
                    rf_gate <= 1'b0;
                    burst_pipe <= {BURST_DELAY{1'b0}};
                    event_out <= 1'b0;
                    ev_cnt <= 4'h0;
                    if (run) begin
                        state <= ST_PLAY;
                    end
                end
                ST_PLAY: begin
                    if (!run) begin
                        state <= ST_IDLE;
                    end else if (tick) begin
                        div_cnt <= 16'h0000;
                        symbol_strobe <= 1'b1; // R15
                        cur_byte <= rd_byte;
                        // Upper 24 bits device-added: valid flag and address
                        expanded_word <= {7'h00, is_valid(rd_byte), {(16-AW){1'b0}}, play_addr, rd_byte}; // R12 R18
                        payload_bit <= rd_byte[`PMP_BIT_BURST] & rd_byte[`PMP_BIT_DATA]; // R01 R02 R06
                        burst_pipe <= {burst_pipe[BURST_DELAY-2:0], rd_byte[`PMP_BIT_BURST]}; // R17
                        rf_gate <= burst_pipe[BURST_DELAY-1]; // R03
                        event_out <= next_event_out; // R08
                        ev_cnt <= next_ev_cnt;
                        play_addr <= next_play_addr; // R10
                        byte_cnt <= next_byte_cnt;
                    end else begin
                        div_cnt <= div_cnt + 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// File: pmp_checker_assertions.sv
// Port checker for pmp_playback
// Assumes it is bound to pmp_playback with a rate of one or more cycles per symbol
`timescale 1ns/1ps
module pmp_checker (
    input wire sys_clk,
    input wire srst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire payload_bit,
    input wire event_out,
    input wire symbol_strobe,
    input wire [31:0] expanded_word
);
    reg run_ok;
    reg last_mid;
    reg last_rst;
    reg [11:0] len;
    reg [11:0] last_addr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Track enable, length and the last played byte
    always @(posedge sys_clk) begin
        if (srst) begin
            run_ok <= 1'b0;
            last_mid <= 1'b0;
            last_rst <= 1'b1;
        end else begin
            if (symbol_strobe) begin
                last_mid <= !expanded_word[7] && expanded_word[19:8] != len - 12'h001;
                last_rst <= expanded_word[7];
            end
            // Only a start from idle plays from zero; a late strobe keeps its order
            if (reg_wr && reg_addr == 4'h0) begin
                run_ok <= reg_wdata[0] && !reg_wdata[2] && !(reg_wdata[1] && reg_wdata[3]);
                if (!run_ok) begin
                    last_mid <= 1'b0;
                    last_rst <= 1'b1;
                end
            end
        end
        if (reg_wr && reg_addr == 4'h2) len <= reg_wdata[11:0];
        if (symbol_strobe) last_addr <= expanded_word[19:8];
    end
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read slot");
    a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h5 |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_word_top: assert property (expanded_word[31:25] == 7'h00 && expanded_word[24] == (expanded_word[5:4] == 2'b01 && expanded_word[3] == 1'b0 && expanded_word[1] == 1'b0))
        else $error("word top bits wrong");
    a_idle_quiet: assert property (!run_ok [*4] |-> !symbol_strobe) else $error("playing while off");
    a_restart_zero: assert property (symbol_strobe && last_rst |-> expanded_word[19:8] == 12'h000)
        else $error("no restart at zero");
    a_addr_step: assert property (symbol_strobe && last_mid |-> expanded_word[19:8] == last_addr + 12'h001)
        else $error("address not sequential");
    a_payload_burst: assert property (payload_bit == (expanded_word[2] && expanded_word[0]))
        else $error("payload without burst");
    a_event_source: assert property ($rose(event_out) |-> expanded_word[6] || $past(expanded_word[6]))
        else $error("event without event bit");
endmodule

// File: pmp_host_model.sv
// Controller model: loads patterns and drives the register port
// Assumes strobes are taken on the rising edge of sys_clk
`timescale 1ns/1ps
module pmp_host_model (
    input wire sys_clk,
    output reg [3:0] reg_addr,
    output reg [31:0] reg_wdata,
    output reg reg_wr,
    output reg reg_rd
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task access(input [3:0] a, input [31:0] d, input w);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= w;
            reg_rd <= !w;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            reg_wdata <= ~d;
            #1;
        end
    endtask
    // Four bytes, first byte in the low lane, restart bit only in the last
    task load(input [31:0] p);
        integer i;
        begin
            access(4'h3, 32'h0, 1'b1);
            for (i = 0; i < 4; i = i + 1) access(4'h4, {24'h0, p[8*i +: 8]}, 1'b1);
            access(4'h2, 32'h4, 1'b1);
        end
    endtask
endmodule

// File: pmp_playback_test.sv
// Self-checking bench for pmp_playback driven through pmp_host_model
// Assumes the checker and host model files are compiled first
`timescale 1ns/1ps
`include "pmp_map.vh"
module pmp_playback_test;
    reg sys_clk = 1'b0;
    reg srst = 1'b1;
    wire [3:0] reg_addr;
    wire [31:0] reg_wdata;
    wire reg_wr;
    wire reg_rd;
    wire [31:0] reg_rdata;
    wire payload_bit;
    wire rf_gate;
    wire event_out;
    wire symbol_strobe;
    wire [31:0] expanded_word;
    integer fail_count = 0;
    integer compares = 0;
    integer cyc = 0;
    integer r;
    integer n;
    integer rises;
    integer high;
    reg prev;
    reg [55:0] row;
    // Rows: ctrl, pattern, gate and payload, event count
    localparam [279:0] TAB = {56'h01_95151515_11_00, 56'h71_d4141414_10_0a, 56'h01_91111111_00_00,
        56'h01_85351d17_11_00, 56'h03_95551555_11_14};
    always #4 sys_clk = ~sys_clk;
    pmp_playback pmp_playback_inst (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .payload_bit(payload_bit), .rf_gate(rf_gate),
        .event_out(event_out), .symbol_strobe(symbol_strobe), .expanded_word(expanded_word));
    pmp_host_model pmp_host_model_inst (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    task check(input [31:0] got, input [31:0] want);
        begin
            compares = compares + 1;
            if (got !== want) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, want);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (fail_count == 0 && compares > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            report_and_stop;
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        pmp_host_model_inst.access(4'h0, 32'h0, 1'b0);
        check(reg_rdata, {24'h0, `PMP_CTRL_RESET});
        pmp_host_model_inst.access(4'hf, 32'h0, 1'b0);
        check(reg_rdata, 32'h0);
        for (r = 0; r < 5; r = r + 1) begin
            row = TAB[(4 - r) * 56 +: 56];
            pmp_host_model_inst.access(4'h0, 32'h0, 1'b1);
            pmp_host_model_inst.load(row[47:16]);
            pmp_host_model_inst.access(4'h5, 32'h1, 1'b1);
            pmp_host_model_inst.access(4'h0, {24'h0, row[55:48]}, 1'b1);
            n = 0;
            rises = 0;
            high = 0;
            prev = 1'b0;
            while (n < 60) begin
                @(posedge sys_clk);
                #1;
                if (symbol_strobe) n = n + 1;
                if (n >= 20 && n < 60) begin
                    rises = rises + (event_out && !prev);
                    high = high + event_out;
                    check({31'h0, rf_gate}, {31'h0, row[12]});
                    check({31'h0, payload_bit}, {31'h0, row[8]});
                    if (symbol_strobe) check(expanded_word[7:0], row[16 + 8 * ((n - 1) % 4) +: 8]);
                    if (symbol_strobe) check(expanded_word[19:8], (n - 1) % 4);
                end
                prev = event_out;
            end
            check(rises, row[7:0]);
            check(high, rises * (row[52] ? row[55:53] : 1) * 2);
        end
        pmp_host_model_inst.access(4'h2, 32'h0, 1'b0);
        check(reg_rdata, 32'h4);
        pmp_host_model_inst.access(4'h5, 32'h0, 1'b0);
        check(reg_rdata, 32'h1);
        for (r = 0; r < 2; r = r + 1) begin
            pmp_host_model_inst.access(4'h0, 32'h0, 1'b1);
            pmp_host_model_inst.access(4'h0, r ? 32'h05 : 32'h0b, 1'b1);
            n = 0;
            repeat (40) begin
                @(posedge sys_clk);
                #1;
                n = n + symbol_strobe;
            end
            check(n, 32'h0);
            pmp_host_model_inst.access(4'h1, 32'h0, 1'b0);
            check(reg_rdata[15:0], 32'h0);
        end
        report_and_stop;
    end
endmodule
bind pmp_playback pmp_checker pmp_checker_inst (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .payload_bit(payload_bit),
    .event_out(event_out), .symbol_strobe(symbol_strobe), .expanded_word(expanded_word));
